// ==== hw/eie_params.svh ====
`ifndef EIE_PARAMS_SVH
`define EIE_PARAMS_SVH
// escape prefix and second-byte encodings
`define EIE_ESCAPE        8'ha5
`define EIE_OP_BREAK      8'h00
`define EIE_OP_ASR        8'h03
`define EIE_OP_MOVC_ALT   8'h07
`define EIE_OP_LSL        8'h13
`define EIE_OP_CLR        8'h06
`define EIE_OP_JMP_APC    8'h73
`define EIE_OP_MOV_ALT    8'h90
`define EIE_OP_INC_ALT    8'ha3
`define EIE_OP_MAC        8'ha4
`define EIE_OP_MOVX_RD    8'he0
`define EIE_OP_MOVX_WR    8'hf0
// cycle counts per instruction
`define EIE_CYC_JMP       4'h3
`define EIE_CYC_SHIFT     4'h2
`define EIE_CYC_MOVC      4'h4
`define EIE_CYC_MOVI      4'h3
`define EIE_CYC_INC       4'h3
`define EIE_CYC_MAC       4'h9
`define EIE_CYC_X_ONCHIP  4'h3
`define EIE_CYC_X_OTHER   4'h5
`define EIE_CYC_BREAK     4'h2
// pc advance for a two-byte instruction
`define EIE_PC_STEP       16'h0002
// reset values
`define EIE_MAC_RST       40'h00_0000_0000
`define EIE_DPTR_RST      16'h0000
`endif

// ==== hw/eie_pkg.sv ====
package eie_pkg;
  // target space of an external access
  typedef enum logic [1:0] {
    eie_space_onchip,
    eie_space_flash,
    eie_space_external
  } eie_space_type;
  // memory request toward program/data memories
  typedef struct packed {
    logic        code_rd;
    logic        data_rd;
    logic        data_wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } eie_mem_req_type;
  // flag update toward the core
  typedef struct packed {
    logic ov_set;
    logic cy_wr;
    logic cy_val;
  } eie_flag_upd_type;
endpackage

// ==== hw/eie_decoder.sv ====
`timescale 1ns/1ns
`include "eie_params.svh"
// Notes on behaviour
// - escape byte then second byte picks operation
// - relative jump target is A plus PC+2
// - jump wraps 16 bits, A and flags kept
// - mac shift left, zero into bit 0
// - code lookup at A plus alternate pointer
// - immediate load: high byte, then low
// - alternate pointer is second when select low
// - signed 16x16 product added into mac
// - overflow sets flag, never clears it
// - carry follows sign of mac result
// - external read via alternate pointer, 3/5 cycles
// - external write via alternate pointer, same cycles
// - break without debug is two-cycle nop, except directly after an increment it steps the alternate pointer
// - break with debug enters debug handler
module eie_decoder (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // -------------------------------------------------------------------
  // fetch side
  // -------------------------------------------------------------------
  input  wire logic                      byte_valid,       // fetched byte present
  input  wire logic [7:0]                byte_data,        // fetched byte
  input  wire logic [15:0]               pc_in,            // address of escape byte
  output logic                           busy,             // block owns the core
  output logic                           done,             // one-cycle completion
  output logic                           pc_load,          // load next fetch address
  output logic [15:0]                    pc_next,          // next fetch address
  // -------------------------------------------------------------------
  // core registers
  // -------------------------------------------------------------------
  input  wire logic [7:0]                acc,              // accumulator
  input  wire logic [7:0]                breg,             // b register
  input  wire logic [7:0]                acc_high_extension,
  input  wire logic [7:0]                b_high_extension,
  input  wire logic                      pointer_select_bit,
  input  wire logic                      on_chip_debug,    // debug enabled
  output logic                           acc_load,         // write accumulator
  output logic [7:0]                     acc_next,         // value for accumulator
  output eie_pkg::eie_flag_upd_type      flag_upd,         // flag updates
  output logic                           debug_enter,      // hand to debug handler
  output logic [15:0]                    first_data_pointer,
  output logic [15:0]                    second_data_pointer,
  output logic [39:0]                    mac_value,        // mac register
  // -------------------------------------------------------------------
  // memory side
  // -------------------------------------------------------------------
  input  wire eie_pkg::eie_space_type    data_space,       // space of current address
  output eie_pkg::eie_mem_req_type       mem_req,          // memory request
  input  wire logic [7:0]                mem_rdata         // read data, valid at done
);

  // -------------------------------------------------------------------
  // types and helpers
  // -------------------------------------------------------------------
  // sequencer states
  typedef enum logic [2:0] {
    eie_st_idle,       // waiting for escape
    eie_st_op,         // waiting for second byte
    eie_st_imm_hi,     // waiting for high immediate
    eie_st_imm_lo,     // waiting for low immediate
    eie_st_exec        // counting down cycles
  } eie_state_type;

  // 16-bit unsigned add of byte to word, wraps
  function automatic logic [15:0] add_byte(input logic [15:0] base, input logic [7:0] b);
    add_byte = base + {8'h00, b};
  endfunction

  // every escaped op not listed here completes on its opcode byte
  function automatic logic is_short(input logic [7:0] op);
    is_short = !(op == `EIE_OP_JMP_APC || op == `EIE_OP_MOVC_ALT ||
                 op == `EIE_OP_MAC     || op == `EIE_OP_INC_ALT  ||
                 op == `EIE_OP_MOV_ALT || op == `EIE_OP_MOVX_RD  ||
                 op == `EIE_OP_MOVX_WR);
  endfunction

  eie_state_type state;           // sequencer state
  logic [7:0]    opcode;          // latched second byte
  logic [3:0]    cnt;             // remaining cycles
  logic [7:0]    imm_hi;          // latched high immediate
  logic [15:0]   pc_base;         // escape byte address
  logic [15:0]   alt_ptr;         // unselected pointer
  logic          finish;          // last execute cycle
  logic [31:0]   product;         // signed product
  logic [39:0]   mac_sum;         // mac plus product
  logic          mac_ovf;         // two's complement overflow
  logic [7:0]    cur_op;          // opcode now in effect
  logic          short_done;      // two-cycle op ends on opcode byte

  // unselected pointer choice
  assign alt_ptr = pointer_select_bit ? first_data_pointer : second_data_pointer;
  // two-cycle ops finish in the cycle their opcode byte arrives
  assign short_done = (state == eie_st_op) && byte_valid && is_short(byte_data);
  // the opcode byte is still on the bus during its own cycle
  assign cur_op     = (state == eie_st_op) ? byte_data : opcode;
  assign finish     = short_done || ((state == eie_st_exec) && (cnt == 4'h1));

  // signed multiply accumulate
  assign product = 32'($signed({acc_high_extension, acc}) *
                       $signed({b_high_extension, breg}));
  // product sign-extended to forty bits
  assign mac_sum = mac_value + {{8{product[31]}}, product};
  // overflow when both addends share a sign the sum lacks
  assign mac_ovf = (mac_value[39] == product[31]) && (mac_sum[39] != mac_value[39]);

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  // steps escape, opcode, immediates, then a countdown
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state   <= eie_st_idle;
      opcode  <= 8'h00;
      cnt     <= 4'h0;
      imm_hi  <= 8'h00;
      pc_base <= 16'h0000;
    end else begin
      case (state)
        // idle: only an escape byte matters
        eie_st_idle: begin
          // escape prefix starts an extended instruction
          if (byte_valid && byte_data == `EIE_ESCAPE) begin
            state   <= eie_st_op;
            pc_base <= pc_in;
          end
        end
        // opcode byte; no byte means wait
        eie_st_op: begin
          if (byte_valid) begin
            opcode <= byte_data;
            // cycles already spent: escape and opcode fetch
            if (byte_data == `EIE_OP_MOV_ALT) begin
              state <= eie_st_imm_hi;
            end else if (is_short(byte_data)) begin
              // shift, clear, break and unknown codes end here
              state <= eie_st_idle;
            end else begin
              state <= eie_st_exec;
              case (byte_data)
                `EIE_OP_JMP_APC:  cnt <= `EIE_CYC_JMP - 4'h2;
                `EIE_OP_MOVC_ALT: cnt <= `EIE_CYC_MOVC - 4'h2;
                `EIE_OP_MAC:      cnt <= `EIE_CYC_MAC - 4'h2;
                `EIE_OP_INC_ALT:  cnt <= `EIE_CYC_INC - 4'h2;
                `EIE_OP_MOVX_RD,
                `EIE_OP_MOVX_WR: begin
                  // onchip space is faster than flash or external
                  if (data_space == eie_pkg::eie_space_onchip) begin
                    cnt <= `EIE_CYC_X_ONCHIP - 4'h2;
                  end else begin
                    cnt <= `EIE_CYC_X_OTHER - 4'h2;
                  end
                end
                default:          cnt <= `EIE_CYC_SHIFT - 4'h1;  // short ops end above
              endcase
            end
          end
        end
        // high immediate byte comes first
        eie_st_imm_hi: begin
          if (byte_valid) begin
            imm_hi <= byte_data;
            state  <= eie_st_imm_lo;
          end
        end
        // low byte; pointer written on this edge
        eie_st_imm_lo: begin
          if (byte_valid) begin
            state <= eie_st_exec;
            cnt   <= 4'h1;
          end
        end
        // count down to the last cycle
        eie_st_exec: begin
          cnt <= cnt - 4'h1;
          // back to idle after the last cycle
          if (cnt == 4'h1) begin
            state <= eie_st_idle;
          end
        end
        // stray state code falls back to idle
        default: state <= eie_st_idle;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // mac register
  // -------------------------------------------------------------------
  // forty-bit accumulator, reset to zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mac_value <= `EIE_MAC_RST;
    end else if (finish) begin
      // only shift, clear and mac touch the register
      // short ops use the opcode byte still on the bus
      case (cur_op)
        `EIE_OP_LSL: mac_value <= {mac_value[38:0], 1'b0};
        `EIE_OP_ASR: mac_value <= {mac_value[39], mac_value[39:1]};
        `EIE_OP_CLR: mac_value <= `EIE_MAC_RST;
        `EIE_OP_MAC: mac_value <= mac_sum;
        // every other op keeps the value
        default:     mac_value <= mac_value;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // data pointers
  // -------------------------------------------------------------------
  // two pointers, only the unselected one is written
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      first_data_pointer  <= `EIE_DPTR_RST;
      second_data_pointer <= `EIE_DPTR_RST;
    end else if (state == eie_st_imm_lo && byte_valid) begin
      // immediate into unselected pointer
      if (pointer_select_bit) begin
        first_data_pointer <= {imm_hi, byte_data};
      end else begin
        second_data_pointer <= {imm_hi, byte_data};
      end
    end else if (finish && opcode == `EIE_OP_INC_ALT) begin
      // increment with wrap
      // unselected pointer steps by one
      if (pointer_select_bit) begin
        first_data_pointer <= first_data_pointer + 16'h0001;
      end else begin
        second_data_pointer <= second_data_pointer + 16'h0001;
      end
    end
  end

  // -------------------------------------------------------------------
  // completion outputs
  // -------------------------------------------------------------------
  // done and pc_load follow finish; the other strobes default low and the case below raises them per opcode
  always_comb begin
    // busy from opcode cycle through done
    busy        = (state != eie_st_idle);
    done        = finish;
    pc_load     = finish;
    // plain advance past the two instruction bytes
    pc_next     = pc_base + `EIE_PC_STEP;
    acc_load    = 1'b0;
    // read data passes straight through to the accumulator
    acc_next    = mem_rdata;
    // flags, debug and memory stay quiet unless decoded
    flag_upd    = '0;
    debug_enter = 1'b0;
    mem_req     = '0;
    // short ops act in the opcode cycle, long ops while counting
    if (state == eie_st_exec || short_done) begin
      case (cur_op)
        `EIE_OP_JMP_APC: begin
          // target A plus PC+2, wraps, A untouched
          pc_next = add_byte(pc_base + `EIE_PC_STEP, acc);
        end
        `EIE_OP_MOV_ALT: begin
          // four bytes fetched for the immediate form
          pc_next = pc_base + `EIE_PC_STEP + `EIE_PC_STEP;
        end
        `EIE_OP_MOVC_ALT: begin
          // code byte at A plus alternate pointer
          mem_req.code_rd = 1'b1;
          mem_req.addr    = add_byte(alt_ptr, acc);
          acc_load        = finish;
        end
        `EIE_OP_MOVX_RD: begin
          // read held for whole execute, data taken at done
          mem_req.data_rd = 1'b1;
          mem_req.addr    = alt_ptr;
          acc_load        = finish;
        end
        `EIE_OP_MOVX_WR: begin
          // write strobe only in the last cycle
          mem_req.data_wr = finish;
          mem_req.addr    = alt_ptr;
          mem_req.wdata   = acc;
        end
        `EIE_OP_MAC: begin
          // flags only move in the last cycle
          if (finish) begin
            flag_upd.ov_set = mac_ovf;
            flag_upd.cy_wr  = 1'b1;
            flag_upd.cy_val = mac_sum[39];
          end
        end
        `EIE_OP_BREAK: begin
          // disabled debug leaves a plain nop, except directly after an increment, when the alternate pointer steps again
          debug_enter = finish && on_chip_debug;
        end
        default: begin
          // other codes drive nothing beyond the defaults
        end
      endcase
    end
  end

endmodule

// ==== dv/eie_decoder_monitor.sv ====
`timescale 1ns/1ns
module eie_decoder_monitor (
  input wire logic                       clk_sys,
  input wire logic                       nrst,
  input wire logic                       byte_valid,
  input wire logic [7:0]                 byte_data,
  input wire logic [15:0]                pc_in,
  input wire logic                       busy,
  input wire logic                       done,
  input wire logic                       pc_load,
  input wire logic [15:0]                pc_next,
  input wire logic [7:0]                 acc,
  input wire logic                       pointer_select_bit,
  input wire logic                       on_chip_debug,
  input wire logic                       acc_load,
  input wire eie_pkg::eie_flag_upd_type  flag_upd,
  input wire logic                       debug_enter,
  input wire logic [15:0]                second_data_pointer,
  input wire logic [39:0]                mac_value,
  input wire eie_pkg::eie_mem_req_type   mem_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // escape byte taken in idle, then the opcode byte
  sequence esc(logic [7:0] op);
    !busy && byte_valid && byte_data == 8'ha5 ##1 byte_valid && byte_data == op;
  endsequence
  a_done_pc_load: assert property (done == pc_load)
    else $error("pc load apart from done");
  a_jump_target: assert property (esc(8'h73) |=> done &&
    pc_next == $past(pc_in, 2) + 16'h0002 + {8'h00, acc}) else $error("jump target wrong");
  a_shift_left: assert property (esc(8'h13) |-> done ##1
    mac_value == {$past(mac_value[38:0]), 1'b0}) else $error("mac shift wrong");
  a_mac_only: assert property ($changed(mac_value) |-> $past(done))
    else $error("mac changed outside an instruction");
  a_mac_carry: assert property (esc(8'ha4) |-> ##7 done && flag_upd.cy_wr ##1
    mac_value[39] == $past(flag_upd.cy_val)) else $error("mac carry wrong");
  a_flag_time: assert property (|flag_upd |-> done)
    else $error("flag update outside done");
  a_acc_load: assert property (acc_load |-> done) else $error("acc load outside done");
  a_break_debug: assert property (debug_enter |-> done && on_chip_debug)
    else $error("debug entry wrong");
  a_imm_load: assert property (esc(8'h90) ##0 !pointer_select_bit ##1 byte_valid
    ##1 byte_valid |=> done && second_data_pointer == {$past(byte_data, 2), $past(byte_data)})
    else $error("pointer load wrong");
  a_write_alt: assert property (esc(8'hf0) ##0 !pointer_select_bit |-> ##[1:4]
    done && mem_req.data_wr && mem_req.addr == second_data_pointer && mem_req.wdata == acc)
    else $error("external write wrong");
  c_jump: cover property (esc(8'h73));
  c_overflow: cover property (done && flag_upd.ov_set);
  c_debug: cover property (debug_enter);
endmodule
bind eie_decoder eie_decoder_monitor u_monitor (.*);

// ==== dv/eie_mem_model.sv ====
`timescale 1ns/1ns
module eie_mem_model (
  input wire logic                      clk_sys,
  input wire eie_pkg::eie_mem_req_type  mem_req,
  output logic [7:0]                    mem_rdata
);
  logic [7:0] idle_pat = 8'h00; // moves every cycle so stale data never matches
  always_ff @(posedge clk_sys) begin
    idle_pat <= idle_pat + 8'h3b;
  end
  // read data is a fixed function of the address
  assign mem_rdata = (mem_req.code_rd || mem_req.data_rd) ?
                     (mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ 8'h5a) : idle_pat;
endmodule

// ==== dv/escaped_instruction_extensions_tb.sv ====
`timescale 1ns/1ns
module escaped_instruction_extensions_tb;
  logic clk_sys = 1'b0, nrst = 1'b0, byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h00, acc = 8'h00, breg = 8'h00;
  logic [7:0] acc_high_extension = 8'h00, b_high_extension = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic pointer_select_bit = 1'b0, on_chip_debug = 1'b0;
  eie_pkg::eie_space_type data_space = eie_pkg::eie_space_onchip;
  logic busy, done, pc_load, acc_load, debug_enter;
  logic [15:0] pc_next, first_data_pointer, second_data_pointer;
  logic [7:0] acc_next, mem_rdata, an;
  logic [39:0] mac_value, em = '0;
  eie_pkg::eie_flag_upd_type flag_upd, fu;
  eie_pkg::eie_mem_req_type mem_req, rq;
  logic [15:0] p0 = '0, p1 = '0, pn, ea, pa;
  logic [31:0] r;
  logic al, de, got;
  int fail_count = 0, tests_run = 0, seed = 45442, i, j;
  eie_decoder DUT (.*);
  eie_mem_model u_mem (.*);
  always #5 clk_sys = ~clk_sys;
  function automatic logic [7:0] rd(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // escape, opcode and data bytes back to back; done-cycle outputs captured
  task automatic ins(input logic [7:0] op, hi, lo, input int cyc);
    logic [7:0] b [4];
    int n;
    b = '{8'ha5, op, hi, lo};
    n = 0;
    got = 1'b0;
    while (n < 20 && !got) begin
      @(posedge clk_sys);
      #1;
      byte_valid = n < ((op == 8'h90) ? 4 : 2);
      byte_data = (n < 4) ? b[n] : 8'h00;
      n++;
      #1;
      if (done === 1'b1) begin
        got = 1'b1;
        pn = pc_next; an = acc_next; al = acc_load; fu = flag_upd; de = debug_enter; rq = mem_req;
      end
    end
    if (!got) begin
      fail_count++;
      tally_and_finish;
    end
    chk(n, cyc);
  endtask
  task automatic mac_op(input logic [15:0] x, y);
    logic [39:0] pr, s;
    {acc_high_extension, acc} = x;
    {b_high_extension, breg} = y;
    pr = $signed(x) * $signed(y);
    s = em + pr;
    ins(8'ha4, 8'h00, 8'h00, 9);
    chk(fu.ov_set, em[39] == pr[39] && s[39] != em[39]);
    chk(fu.cy_val, s[39]);
    em = s;
    @(posedge clk_sys);
    #1 chk(mac_value, em);
  endtask
  task automatic lsl;
    ins(8'h13, 8'h00, 8'h00, 2);
    chk(fu, 3'b000);
    em = {em[38:0], 1'b0};
    @(posedge clk_sys);
    #1 chk(mac_value, em);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 nrst = 1'b1;
    // relative jump, wrap corner first
    for (i = 0; i < 5; i++) begin
      r = $random(seed);
      pc_in = i ? r[15:0] : 16'hfffe;
      acc = i ? r[23:16] : 8'hff;
      ins(8'h73, 8'h00, 8'h00, 3);
      chk({al, pn}, {1'b0, pc_in + 16'h0002 + {8'h00, acc}});
    end
    // mac pushed toward overflow by shifts
    mac_op(16'h7fff, 16'h7fff);
    repeat (9) lsl();
    mac_op(16'h7fff, 16'h7fff);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      mac_op(r[15:0], r[31:16]);
    end
    // arithmetic right shift keeps the sign, then clear
    ins(8'h03, 8'h00, 8'h00, 2);
    em = {em[39], em[39:1]};
    @(posedge clk_sys);
    #1 chk(mac_value, em);
    ins(8'h06, 8'h00, 8'h00, 2);
    em = '0;
    @(posedge clk_sys);
    #1 chk(mac_value, em);
    for (i = 0; i < 2; i++) begin
      pointer_select_bit = i[0];
      r = $random(seed);
      ins(8'h90, r[15:8], r[7:0], 5);
      if (i) p0 = r[15:0];
      else p1 = r[15:0];
      chk({first_data_pointer, second_data_pointer, pn}, {p0, p1, pc_in + 16'h0004});
      // increment of the unselected pointer
      ins(8'ha3, 8'h00, 8'h00, 3);
      if (i) p0 = p0 + 16'h0001;
      else p1 = p1 + 16'h0001;
      @(posedge clk_sys);
      #1 chk({first_data_pointer, second_data_pointer}, {p0, p1});
    end
    for (i = 0; i < 2; i++) begin
      pointer_select_bit = i[0];
      r = $random(seed);
      acc = r[7:0];
      pa = i ? p0 : p1;
      ea = pa + {8'h00, acc};
      ins(8'h07, 8'h00, 8'h00, 4);
      chk({al, an, rq.code_rd, rq.addr}, {1'b1, rd(ea), 1'b1, ea});
      for (j = 0; j < 3; j++) begin
        data_space = eie_pkg::eie_space_type'(j[1:0]);
        ins(8'he0, 8'h00, 8'h00, j ? 5 : 3);
        chk({al, an, rq.addr}, {1'b1, rd(pa), pa});
        ins(8'hf0, 8'h00, 8'h00, j ? 5 : 3);
        chk({al, rq.data_wr, rq.wdata, rq.addr}, {1'b0, 1'b1, acc, pa});
      end
      on_chip_debug = i[0];
      ins(8'h00, 8'h00, 8'h00, 2);
      chk({de, pn}, {i[0], pc_in + 16'h0002});
    end
    tally_and_finish;
  end
endmodule
